// *** pdl_consts.svh ***
// constants for the paged diagnostic live status register bank
// assumes inclusion by bare name from the design file and the bench
`ifndef PDL_CONSTS_SVH
`define PDL_CONSTS_SVH
`define PDL_PAGE_SELECT_OFS   8'h00
`define PDL_LOAD_SINK_OFS     8'h16
`define PDL_LIVE_EVENT_OFS    8'h2c
`define PDL_CHAN_SUMMARY_OFS  8'h2d
`define PDL_THIS_PAGE         8'h01
`define PDL_PAGE_RESET        8'h00
`define PDL_SINK_CODE_RESET   3'h0
`define PDL_SINK_SEL_BIT      7
`define PDL_SINK_CODE_HI      6
`define PDL_SINK_CODE_LO      4
`define PDL_EVT_CLK_ERR_BIT   7
`define PDL_EVT_PLL_LOCK_BIT  6
`define PDL_EVT_OVER_TEMP_BIT 5
`define PDL_EVT_OVER_CUR_BIT  4
`define PDL_SUM_SHORT_BAT_BIT 1
`define PDL_NUM_CHANNELS      4
`endif

// *** pdl_pkg.sv ***
// types for the paged diagnostic live status register bank
// assumes pdl_consts.svh is on the include path
package pdl_pkg;
    typedef logic [7:0] pdl_byte_t;
    typedef logic [2:0] pdl_sink_code_t;
endpackage

// *** pdl_regs.sv ***
// register bank of page one: page select, bias load sink, live status
// assumes a byte-wide control port decoded outside, faults synchronous to mclk
`timescale 1ns/1ps
`include "pdl_consts.svh"

module pdl_regs
    import pdl_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           srst,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    input  wire logic [7:0]     reg_addr,
    input  wire logic [7:0]     reg_wdata,
    output logic      [7:0]     reg_rdata,
    output logic      [7:0]     page_sel,
    output logic                sink_manual_select,
    output logic      [2:0]     sink_current_code,
    input  wire logic [2:0]     sink_auto_code,
    output logic      [2:0]     sink_drive_code,
    input  wire logic           clk_err_det,
    input  wire logic           pll_lock_det,
    input  wire logic           over_temp_det,
    input  wire logic           over_cur_det,
    input  wire logic [31:0]    channel_fault_detail,
    input  wire logic           short_bat_low_det
);

    // configuration state
    pdl_byte_t      page_q, page_d;
    logic           sel_q, sel_d;
    pdl_sink_code_t code_q, code_d;
    pdl_byte_t      rdata_q, rdata_d;
    logic [3:0]     chan_flag;
    logic           on_page;
    pdl_byte_t      event_word, summary_word, sink_word;

    // page select is reachable on every page; the rest only on page one
    assign on_page = (page_q == `PDL_THIS_PAGE);

    // per channel fault summary: bit 7 of detail is open input ... bit 0 short bat
    genvar ch;
    generate
        for (ch = 0; ch < `PDL_NUM_CHANNELS; ch++) begin : g_chan
            // channel ch+1 detail byte lives at [8*ch+7:8*ch]
            assign chan_flag[ch] = |channel_fault_detail[8*ch +: 8];
        end
    endgenerate

    // live words are pure combinational views, so nothing latches
    always_comb begin
        event_word = 8'h00;
        event_word[`PDL_EVT_CLK_ERR_BIT]   = clk_err_det;
        event_word[`PDL_EVT_PLL_LOCK_BIT]  = pll_lock_det;
        event_word[`PDL_EVT_OVER_TEMP_BIT] = over_temp_det;
        event_word[`PDL_EVT_OVER_CUR_BIT]  = over_cur_det;
        summary_word = 8'h00;
        summary_word[7:4] = {chan_flag[0], chan_flag[1], chan_flag[2], chan_flag[3]};
        summary_word[`PDL_SUM_SHORT_BAT_BIT] = short_bat_low_det;
        sink_word = {sel_q, code_q, 4'h0};
    end

    // next state of writable fields and read data register
    always_comb begin
        page_d  = page_q;
        sel_d   = sel_q;
        code_d  = code_q;
        rdata_d = rdata_q;
        if (reg_wr && reg_addr == `PDL_PAGE_SELECT_OFS) begin
            page_d = reg_wdata;
        end
        // reserved low bits are dropped; host is expected to write zero there
        if (reg_wr && on_page && reg_addr == `PDL_LOAD_SINK_OFS) begin
            sel_d  = reg_wdata[`PDL_SINK_SEL_BIT];
            code_d = reg_wdata[`PDL_SINK_CODE_HI:`PDL_SINK_CODE_LO];
        end
        if (reg_rd) begin
            if (reg_addr == `PDL_PAGE_SELECT_OFS)
                rdata_d = page_q;
            else if (!on_page)
                rdata_d = 8'h00;
            else if (reg_addr == `PDL_LOAD_SINK_OFS)
                rdata_d = sink_word;
            else if (reg_addr == `PDL_LIVE_EVENT_OFS)
                rdata_d = event_word;
            else if (reg_addr == `PDL_CHAN_SUMMARY_OFS)
                rdata_d = summary_word;
            else
                rdata_d = 8'h00;
        end
    end

    // registers; live status has no storage so writes there cannot stick
    always_ff @(posedge mclk) begin
        if (srst) begin
            page_q  <= `PDL_PAGE_RESET;
            sel_q   <= 1'b0;
            code_q  <= `PDL_SINK_CODE_RESET;
            rdata_q <= 8'h00;
        end else begin
            page_q  <= page_d;
            sel_q   <= sel_d;
            code_q  <= code_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata          = rdata_q;
    assign page_sel           = page_q;
    assign sink_manual_select = sel_q;
    assign sink_current_code  = code_q;
    // analog sink takes the automatic code unless software chose a manual one
    assign sink_drive_code = sel_q ? code_q : sink_auto_code;

    // checks
    sequence s_write_page;
        reg_wr && reg_addr == `PDL_PAGE_SELECT_OFS;
    endsequence

    chk_page_write: assert property (@(posedge mclk) disable iff (srst)
        s_write_page |=> page_q == $past(reg_wdata))
        else $error("page select did not take written value");

    chk_page_reset: assert property (@(posedge mclk)
        srst |=> page_q == 8'h00)
        else $error("page select not zero after reset");

    chk_sink_mux: assert property (@(posedge mclk) disable iff (srst)
        sel_q |-> sink_drive_code == code_q)
        else $error("manual sink code not driven");

    chk_sink_auto: assert property (@(posedge mclk) disable iff (srst)
        !sel_q |-> sink_drive_code == sink_auto_code)
        else $error("automatic sink code not driven");

    chk_sink_read: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && on_page && reg_addr == `PDL_LOAD_SINK_OFS
            |=> reg_rdata[3:0] == 4'h0 && reg_rdata[7] == $past(sel_q))
        else $error("load sink readback wrong");

    chk_event_read: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && on_page && reg_addr == `PDL_LIVE_EVENT_OFS
            |=> reg_rdata == {$past(clk_err_det), $past(pll_lock_det),
                              $past(over_temp_det), $past(over_cur_det), 4'h0})
        else $error("live event readback wrong");

    chk_summary_ch1: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && on_page && reg_addr == `PDL_CHAN_SUMMARY_OFS
            |=> reg_rdata[7] == |$past(channel_fault_detail[7:0])
                && reg_rdata[4] == |$past(channel_fault_detail[31:24]))
        else $error("channel summary order wrong");

    chk_summary_rsvd: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && on_page && reg_addr == `PDL_CHAN_SUMMARY_OFS
            |=> reg_rdata[3:2] == 2'h0 && reg_rdata[0] == 1'b0
                && reg_rdata[1] == $past(short_bat_low_det))
        else $error("summary reserved or short bit wrong");

    chk_live_nowrite: assert property (@(posedge mclk) disable iff (srst)
        reg_wr && reg_addr == `PDL_LIVE_EVENT_OFS |=> $stable(sel_q) && $stable(code_q))
        else $error("write to live register changed state");

    // bus steps shared by the checks below
    sequence s_write_sink;
        reg_wr && on_page && reg_addr == `PDL_LOAD_SINK_OFS;
    endsequence

    sequence s_read_event;
        reg_rd && on_page && reg_addr == `PDL_LIVE_EVENT_OFS;
    endsequence

    sequence s_read_summary;
        reg_rd && on_page && reg_addr == `PDL_CHAN_SUMMARY_OFS;
    endsequence

    sequence s_read_page;
        reg_rd && reg_addr == `PDL_PAGE_SELECT_OFS;
    endsequence

    // load sink fields take the written bits one cycle after the strobe
    chk_sink_sel_write: assert property (@(posedge mclk) disable iff (srst)
        s_write_sink |=> sel_q == $past(reg_wdata[`PDL_SINK_SEL_BIT]))
        else $error("sink select did not take written value");

    chk_sink_code_write: assert property (@(posedge mclk) disable iff (srst)
        s_write_sink |=> code_q == $past(reg_wdata[6:4]))
        else $error("sink code did not take written value");

    // only a page one write to the sink offset may move the sink fields
    chk_sink_hold: assert property (@(posedge mclk) disable iff (srst)
        !(reg_wr && on_page && reg_addr == `PDL_LOAD_SINK_OFS)
            |=> $stable(sel_q) && $stable(code_q))
        else $error("sink fields moved without a write");

    chk_sink_reset: assert property (@(posedge mclk)
        srst |=> !sel_q && code_q == 3'h0)
        else $error("sink fields not zero after reset");

    // page select moves only on its own write, whatever page is current
    chk_page_hold: assert property (@(posedge mclk) disable iff (srst)
        !(reg_wr && reg_addr == `PDL_PAGE_SELECT_OFS) |=> $stable(page_q))
        else $error("page select moved without a write");

    chk_page_read: assert property (@(posedge mclk) disable iff (srst)
        s_read_page |=> reg_rdata == $past(page_q))
        else $error("page select readback wrong");

    // other pages are not modelled here, so all but page select read as zero
    chk_offpage_read: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && !on_page && reg_addr != `PDL_PAGE_SELECT_OFS |=> reg_rdata == 8'h00)
        else $error("read off page one not zero");

    chk_unmapped_read: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && on_page && reg_addr != `PDL_PAGE_SELECT_OFS
            && reg_addr != `PDL_LOAD_SINK_OFS && reg_addr != `PDL_LIVE_EVENT_OFS
            && reg_addr != `PDL_CHAN_SUMMARY_OFS |=> reg_rdata == 8'h00)
        else $error("unmapped offset read not zero");

    // pll lock, over-temp and over-current bits are each checked alone so a swap is caught
    chk_pll_lock: assert property (@(posedge mclk) disable iff (srst)
        s_read_event |=> reg_rdata[`PDL_EVT_PLL_LOCK_BIT] == $past(pll_lock_det))
        else $error("pll lock bit wrong");

    chk_over_temp: assert property (@(posedge mclk) disable iff (srst)
        s_read_event |=> reg_rdata[`PDL_EVT_OVER_TEMP_BIT] == $past(over_temp_det))
        else $error("over temperature bit wrong");

    chk_over_cur: assert property (@(posedge mclk) disable iff (srst)
        s_read_event |=> reg_rdata[`PDL_EVT_OVER_CUR_BIT] == $past(over_cur_det))
        else $error("over current bit wrong");

    chk_event_rsvd: assert property (@(posedge mclk) disable iff (srst)
        s_read_event |=> reg_rdata[3:0] == 4'h0)
        else $error("live event reserved bits not zero");

    // middle channels complete the order check of the summary
    chk_summary_mid: assert property (@(posedge mclk) disable iff (srst)
        s_read_summary |=> reg_rdata[6] == |$past(channel_fault_detail[15:8])
            && reg_rdata[5] == |$past(channel_fault_detail[23:16]))
        else $error("channel summary middle bits wrong");

    // any single detail bit of channel one must raise its flag
    chk_summary_detail: assert property (@(posedge mclk) disable iff (srst)
        s_read_summary ##0 (channel_fault_detail[7:0] != 8'h00) |=> reg_rdata[7])
        else $error("channel one fault not summarised");

    chk_summary_nowrite: assert property (@(posedge mclk) disable iff (srst)
        reg_wr && reg_addr == `PDL_CHAN_SUMMARY_OFS
            |=> $stable(sel_q) && $stable(code_q) && $stable(page_q))
        else $error("write to summary changed state");

    // read data stands until the next read strobe
    chk_rdata_hold: assert property (@(posedge mclk) disable iff (srst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");

    chk_rdata_reset: assert property (@(posedge mclk)
        srst |=> reg_rdata == 8'h00)
        else $error("read data not zero after reset");

    // the analog sink must follow a manual code one cycle after it is written
    chk_drive_follow: assert property (@(posedge mclk) disable iff (srst)
        s_write_sink ##0 reg_wdata[`PDL_SINK_SEL_BIT]
            |=> sink_drive_code == $past(reg_wdata[6:4]))
        else $error("manual code not on sink after write");

    // the summary never reports more than the detail inputs hold
    chk_summary_quiet: assert property (@(posedge mclk) disable iff (srst)
        s_read_summary ##0 (channel_fault_detail == 32'h0) ##0 !short_bat_low_det
            |=> reg_rdata == 8'h00)
        else $error("summary not zero without faults");

endmodule // pdl_regs

// *** pdl_regs_tb.sv ***
// self-checking bench for the page one register bank
// assumes pdl_pkg, pdl_regs and pdl_consts.svh are compiled alongside
`timescale 1ns/1ps
`include "pdl_consts.svh"

module pdl_regs_tb
    import pdl_pkg::*;
;
    logic        mclk, srst, reg_wr, reg_rd, sink_manual_select, short_bat;
    pdl_byte_t   reg_addr, reg_wdata, reg_rdata, page_sel;
    logic [2:0]  sink_current_code, sink_drive_code;
    logic [3:0]  live;      // clock error, pll lock, over-temp, over-current
    logic [31:0] detail;
    int          fail_count, n_tests;

    // clock generator, 25 ns period
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    pdl_regs DUT (.mclk(mclk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .page_sel(page_sel), .sink_manual_select(sink_manual_select),
        .sink_current_code(sink_current_code), .sink_auto_code(3'h5),
        .sink_drive_code(sink_drive_code), .clk_err_det(live[3]),
        .pll_lock_det(live[2]), .over_temp_det(live[1]), .over_cur_det(live[0]),
        .channel_fault_detail(detail), .short_bat_low_det(short_bat));

    task automatic complete_run();
        if (fail_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input pdl_byte_t exp, input pdl_byte_t got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one write strobe; effect is settled 1 ns after the taking edge
    task automatic wr(input pdl_byte_t a, input pdl_byte_t d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // one read strobe, data registered at the taking edge
    task automatic rd_chk(input pdl_byte_t a, input pdl_byte_t exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask

    // hang guard: a stuck run still reaches the verdict
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        complete_run();
    end

    // main sequence
    initial begin
        {srst, reg_wr, reg_rd, reg_addr, reg_wdata, short_bat} = {3'b100, 17'h0};
        {live, detail, fail_count, n_tests} = '0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk("page_sel", 8'h00, page_sel);
        chk("drive", 8'h05, {5'h0, sink_drive_code});
        wr(8'h16, 8'hff);
        rd_chk(8'h16, 8'h00);
        wr(8'h00, 8'h01);
        rd_chk(8'h00, 8'h01);
        wr(8'h16, 8'hff);
        rd_chk(8'h16, 8'hf0);
        for (int k = 0; k < 8; k++) begin
            wr(8'h16, {1'b1, 3'(k), 4'h0});
            chk("drive", 8'(k), {5'h0, sink_drive_code});
        end
        wr(8'h16, 8'h30);
        chk("code", 8'h03, {5'h0, sink_current_code});
        chk("drive", 8'h05, {5'h0, sink_drive_code});
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            live <= 4'h8 >> i;
            rd_chk(8'h2c, 8'h80 >> i);
        end
        @(posedge mclk);
        live <= 4'h0;
        wr(8'h2c, 8'hff);
        rd_chk(8'h2c, 8'h00);
        for (int i = 0; i < 32; i++) begin
            @(posedge mclk);
            detail <= 32'h1 << i;
            rd_chk(8'h2d, 8'h80 >> (i / 8));
        end
        rd_chk(8'h2e, 8'h00);
        @(posedge mclk);
        detail    <= 32'h0;
        short_bat <= 1'b1;
        wr(8'h2d, 8'hff);
        rd_chk(8'h2d, 8'h02);
        @(posedge mclk);
        short_bat <= 1'b0;
        rd_chk(8'h2d, 8'h00);
        wr(8'h16, 8'hb0);
        wr(8'h00, 8'h02);
        @(posedge mclk);
        live <= 4'h4;
        rd_chk(8'h2c, 8'h00);
        wr(8'h00, 8'hff);
        rd_chk(8'h00, 8'hff);
        // second reset in mid-run, with manual select and code set before it
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk("page_sel", 8'h00, page_sel);
        chk("select", 8'h00, {7'h0, sink_manual_select});
        chk("code", 8'h00, {5'h0, sink_current_code});
        chk("drive", 8'h05, {5'h0, sink_drive_code});
        complete_run();
    end
endmodule // pdl_regs_tb
